//--- rtl/psm_ctrl.sv
// Purpose: idle and power-down control of an 8-bit controller core
// Assumes: instruction completion is flagged by the core for one clock
// Notes:   oscillator, cpu clock and pin controls are plain outputs
`timescale 1ns/1ps
// Operation
// - idle keeps oscillator, gates cpu, stops watchdog
// - idle freezes the complete cpu state
// - idle holds pins, alternate outputs stay live
// - strobes high in idle, low in power-down
// - external code: port0 floats, port2 address/latch
// - port inputs keep working during idle
// - enable and start together never enter idle
// - idle enable and start self-clear, read zero
// - idle begins right after the start instruction
// - enabled interrupt ends idle, resumes after start
// - reset ends idle within two machine cycles
// - power-down stops oscillator, keeps ram and registers
// - power-down freezes alternates, clock output low
// - enable and start together never enter power-down
// - power-down enable and start self-clear, read zero
// - power-down begins right after the start instruction
// - only reset ends power-down, ram kept
// - reset restarts oscillator, held until stable
// - permit pin high ignores both entry sequences
// - simultaneous requests choose power-down
module psm_ctrl
  import psm_pkg::*;
#(
  parameter int unsigned PORT_W = 8
) (
  // clock and reset
  input  wire logic              CLK_I,
  input  wire logic              RST_I,
  // power control register write from the core
  input  wire logic              INSTR_DONE_I,
  input  wire logic              POWER_CONTROL_REGISTER_WR_I,
  input  wire logic [7:0]        POWER_CONTROL_REGISTER_WDATA_I,
  output logic [7:0]             POWER_CONTROL_REGISTER_RDATA_O,
  // permit pin, active low
  input  wire logic              PERMIT_N_I,
  // wake sources
  input  wire logic              IRQ_PENDING_I,
  // core state
  input  wire logic              EXT_CODE_I,
  input  wire logic              ALE_RUN_I,
  input  wire logic              CODE_RD_RUN_I,
  input  wire logic [PORT_W-1:0] P0_LATCH_I,
  input  wire logic [PORT_W-1:0] P2_LATCH_I,
  input  wire logic [PORT_W-1:0] P2_ADDR_I,
  input  wire logic              P0_DRIVE_RUN_I,
  input  wire logic              P2_ADDR_SEL_I,
  input  wire logic [PORT_W-1:0] ALT_OUT_I,
  input  wire logic              CLOCK_OUTPUT_PIN_EN_I,
  input  wire logic              CLOCK_OUTPUT_PIN_RUN_I,
  // clock gating controls
  output logic                   OSC_RUN_O,
  output logic                   CPU_CLK_EN_O,
  output logic                   PERIPH_CLK_EN_O,
  output logic                   WDOG_CLK_EN_O,
  output logic                   IDLE_O,
  output logic                   PDOWN_O,
  output logic                   WAKE_IRQ_O,
  // pin controls
  output logic                   ALE_O,
  output logic                   CODE_RD_O,
  output logic [PORT_W-1:0]      P0_O,
  output logic                   P0_OE_N_O,
  output logic [PORT_W-1:0]      P2_O,
  output logic [PORT_W-1:0]      ALT_O,
  output logic                   CLOCK_OUTPUT_PIN_O
);
  initial begin
    if (PORT_W < 1 || PORT_W > 32) begin
      $error("psm_ctrl: PORT_W out of range");
    end
  end

  psm_mode_t         mode_ff;      // current mode
  psm_mode_t         nxt_mode;     // next mode
  logic [7:0]        power_control_register_ff;      // stored general bits
  logic              idle_fire;    // idle start accepted
  logic              pd_fire;      // power-down start accepted
  logic              permit;       // permit pin low
  logic              ext_ff;       // code source at entry
  logic [PORT_W-1:0] alt_ff;       // frozen alternate outputs
  logic [PORT_W-1:0] p2_ff;        // port 2 address at entry
  logic              clock_output_pin_ff;    // frozen clock output
  logic              ale_ff;       // strobe outputs registered
  logic              crd_ff;

  assign permit = ~PERMIT_N_I;

  psm_arm_gate u_idle_gate (
    .clk_i        (CLK_I),
    .rst_i        (RST_I),
    .instr_done_i (INSTR_DONE_I),
    .wr_i         (POWER_CONTROL_REGISTER_WR_I),
    .arm_bit_i    (POWER_CONTROL_REGISTER_WDATA_I[PSM_IDLE_ARM_POS]),
    .start_bit_i  (POWER_CONTROL_REGISTER_WDATA_I[PSM_IDLE_START_POS]),
    .fire_o       (idle_fire)
  );

  psm_arm_gate u_pd_gate (
    .clk_i        (CLK_I),
    .rst_i        (RST_I),
    .instr_done_i (INSTR_DONE_I),
    .wr_i         (POWER_CONTROL_REGISTER_WR_I),
    .arm_bit_i    (POWER_CONTROL_REGISTER_WDATA_I[PSM_PD_ARM_POS]),
    .start_bit_i  (POWER_CONTROL_REGISTER_WDATA_I[PSM_PD_TRIG_POS]),
    .fire_o       (pd_fire)
  );

  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      power_control_register_ff <= PSM_POWER_CONTROL_REGISTER_RST;
    end else if (POWER_CONTROL_REGISTER_WR_I && mode_ff == PSM_RUN) begin
      power_control_register_ff <= 8'h00;
      power_control_register_ff[PSM_SMOD_POS] <= POWER_CONTROL_REGISTER_WDATA_I[PSM_SMOD_POS];
      power_control_register_ff[PSM_GF1_POS]  <= POWER_CONTROL_REGISTER_WDATA_I[PSM_GF1_POS];
      power_control_register_ff[PSM_GF0_POS]  <= POWER_CONTROL_REGISTER_WDATA_I[PSM_GF0_POS];
    end
  end

  assign POWER_CONTROL_REGISTER_RDATA_O = power_control_register_ff;

  // mode selection
  always_comb begin
    nxt_mode = mode_ff;
    unique case (mode_ff)
      PSM_RUN: begin
        if (permit && pd_fire) begin
          nxt_mode = PSM_PD;
        end else if (permit && idle_fire) begin
          nxt_mode = PSM_IDLE;
        end
      end
      PSM_IDLE: begin
        if (IRQ_PENDING_I) begin
          nxt_mode = PSM_RUN;
        end
      end
      PSM_PD: begin
        nxt_mode = PSM_PD;
      end
      default: begin
        nxt_mode = PSM_RUN;
      end
    endcase
  end

  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      mode_ff <= PSM_RUN;
    end else begin
      mode_ff <= nxt_mode;
    end
  end

  // capture pin state at entry
  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      ext_ff    <= 1'b0;
      alt_ff    <= '0;
      p2_ff     <= '0;
      clock_output_pin_ff <= 1'b0;
    end else if (mode_ff == PSM_RUN) begin
      ext_ff    <= EXT_CODE_I;
      alt_ff    <= ALT_OUT_I;
      // idle on external code shows the fetch address, whatever the mux
      p2_ff     <= P2_ADDR_I;
      clock_output_pin_ff <= CLOCK_OUTPUT_PIN_EN_I & CLOCK_OUTPUT_PIN_RUN_I;
    end
  end

  assign OSC_RUN_O       = (mode_ff != PSM_PD);
  assign CPU_CLK_EN_O    = (mode_ff == PSM_RUN);
  assign PERIPH_CLK_EN_O = (mode_ff != PSM_PD);
  assign WDOG_CLK_EN_O   = (mode_ff == PSM_RUN);
  assign IDLE_O          = (mode_ff == PSM_IDLE);
  assign PDOWN_O         = (mode_ff == PSM_PD);
  assign WAKE_IRQ_O      = (mode_ff == PSM_IDLE) & IRQ_PENDING_I;

  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      ale_ff <= 1'b1;
      crd_ff <= 1'b1;
    end else begin
      unique case (nxt_mode)
        PSM_IDLE: begin
          ale_ff <= 1'b1;
          crd_ff <= 1'b1;
        end
        PSM_PD: begin
          ale_ff <= 1'b0;
          crd_ff <= 1'b0;
        end
        default: begin
          ale_ff <= ALE_RUN_I;
          crd_ff <= CODE_RD_RUN_I;
        end
      endcase
    end
  end

  assign ALE_O     = ale_ff;
  assign CODE_RD_O = crd_ff;

  always_comb begin
    P0_O      = P0_LATCH_I;
    P0_OE_N_O = ~P0_DRIVE_RUN_I;
    P2_O      = P2_ADDR_SEL_I ? P2_ADDR_I : P2_LATCH_I;
    if (mode_ff != PSM_RUN) begin
      P0_OE_N_O = ext_ff;
      P2_O      = (ext_ff && mode_ff == PSM_IDLE) ? p2_ff : P2_LATCH_I;
    end
  end

  always_comb begin
    ALT_O    = ALT_OUT_I;
    CLOCK_OUTPUT_PIN_O = CLOCK_OUTPUT_PIN_EN_I & CLOCK_OUTPUT_PIN_RUN_I;
    if (mode_ff == PSM_PD) begin
      ALT_O    = alt_ff;
      CLOCK_OUTPUT_PIN_O = 1'b0;
    end
  end

  // ---- checks ----
  a_pd_sticky: assert property (
    @(posedge CLK_I) disable iff (RST_I)
    mode_ff == PSM_PD |=> mode_ff == PSM_PD)
    else $error("power-down left without reset");

  a_permit_blocks: assert property (
    @(posedge CLK_I) disable iff (RST_I)
    PERMIT_N_I && mode_ff == PSM_RUN |=> mode_ff == PSM_RUN)
    else $error("mode entered while permit high");

  a_pd_priority: assert property (
    @(posedge CLK_I) disable iff (RST_I)
    permit && pd_fire && idle_fire && mode_ff == PSM_RUN
      |=> mode_ff == PSM_PD)
    else $error("idle chosen over power-down");

  a_both_bits: assert property (
    @(posedge CLK_I) disable iff (RST_I)
    POWER_CONTROL_REGISTER_WR_I && POWER_CONTROL_REGISTER_WDATA_I[PSM_IDLE_ARM_POS]
      && POWER_CONTROL_REGISTER_WDATA_I[PSM_IDLE_START_POS] && !pd_fire
      |=> mode_ff != PSM_IDLE || $past(mode_ff) == PSM_IDLE)
    else $error("idle entered from combined write");

  a_read_zero: assert property (
    @(posedge CLK_I) disable iff (RST_I)
    POWER_CONTROL_REGISTER_RDATA_O[PSM_IDLE_ARM_POS] == 1'b0
      && POWER_CONTROL_REGISTER_RDATA_O[PSM_IDLE_START_POS] == 1'b0
      && POWER_CONTROL_REGISTER_RDATA_O[PSM_PD_ARM_POS] == 1'b0
      && POWER_CONTROL_REGISTER_RDATA_O[PSM_PD_TRIG_POS] == 1'b0)
    else $error("control bit reads nonzero");

  a_idle_entry: assert property (
    @(posedge CLK_I) disable iff (RST_I)
    mode_ff == PSM_RUN && permit && idle_fire && !pd_fire
      |=> IDLE_O && !CPU_CLK_EN_O && OSC_RUN_O)
    else $error("idle not entered at once");

  a_idle_wake: assert property (
    @(posedge CLK_I) disable iff (RST_I)
    mode_ff == PSM_IDLE && IRQ_PENDING_I |=> CPU_CLK_EN_O)
    else $error("interrupt did not end idle");

  a_strobes_pd: assert property (
    @(posedge CLK_I) disable iff (RST_I)
    $rose(PDOWN_O) |-> !ALE_O && !CODE_RD_O)
    else $error("strobes not low in power-down");

  a_clock_output_pin_low: assert property (
    @(posedge CLK_I) disable iff (RST_I)
    PDOWN_O |-> !CLOCK_OUTPUT_PIN_O && (!$past(PDOWN_O) || $stable(ALT_O)))
    else $error("power-down outputs not frozen");

  a_pd_osc_off: assert property (
    @(posedge CLK_I) disable iff (RST_I)
    PDOWN_O |-> !OSC_RUN_O && !PERIPH_CLK_EN_O)
    else $error("oscillator running in power-down");
endmodule : psm_ctrl

//--- rtl/psm_pkg.sv
// Purpose: constants for the power saving mode controller
// Assumes: one 20 MHz clock, power control register written as a byte
// Notes:   bit positions follow the power control register layout
package psm_pkg;
  // power control register field positions
  localparam int unsigned PSM_IDLE_ARM_POS   = 0;
  localparam int unsigned PSM_PD_ARM_POS     = 1;
  localparam int unsigned PSM_GF0_POS        = 2;
  localparam int unsigned PSM_GF1_POS        = 3;
  localparam int unsigned PSM_IDLE_START_POS = 5;
  localparam int unsigned PSM_PD_TRIG_POS    = 6;
  localparam int unsigned PSM_SMOD_POS       = 7;
  // reset value of the stored register bits
  localparam logic [7:0]  PSM_POWER_CONTROL_REGISTER_RST       = 8'h00;
  // clock and machine cycle timing
  localparam int unsigned PSM_CLK_HZ         = 20000000;
  localparam int unsigned PSM_MCYC_CLKS      = 12;
  localparam int unsigned PSM_IDLE_RST_MCYC  = 2;
  localparam int unsigned PSM_IDLE_RST_CLKS  =
    PSM_IDLE_RST_MCYC * PSM_MCYC_CLKS;
  // mode states, gray along run -> idle -> power-down
  typedef enum logic [1:0] {
    PSM_RUN  = 2'b00,
    PSM_IDLE = 2'b01,
    PSM_PD   = 2'b11
  } psm_mode_t;
endpackage : psm_pkg

//--- rtl/psm_arm_gate.sv
// Purpose: two-write arming check for one power saving mode
// Assumes: wr_i marks one completed instruction writing the register
// Notes:   arm is discarded by any other completed instruction
`timescale 1ns/1ps
module psm_arm_gate (
  // clock and reset
  input  wire logic clk_i,
  input  wire logic rst_i,
  // instruction stream
  input  wire logic instr_done_i,
  input  wire logic wr_i,
  input  wire logic arm_bit_i,
  input  wire logic start_bit_i,
  // result
  output logic      fire_o
);
  logic armed_ff;  // enable seen in the previous instruction

  // armed only by a write setting enable without start
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      armed_ff <= 1'b0;
    end else if (instr_done_i) begin
      armed_ff <= wr_i & arm_bit_i & ~start_bit_i;
    end
  end

  // start alone, right after an arming write
  assign fire_o = instr_done_i & wr_i & armed_ff & start_bit_i & ~arm_bit_i;
endmodule : psm_arm_gate

//--- sim/psm_ctrl_tb.sv
// Purpose: self-checking bench for the power saving mode controller
// Assumes: one 50 ns clock, PORT_W of 8, core strobes held high in run
// Notes:   random write bytes keep the stored flags in play each test
`timescale 1ns/1ps
module psm_ctrl_tb
  import psm_pkg::*;
;
  // stimulus toward the design
  logic       clk, rst, done, wr, permit_n, irq, ext;
  logic       p0_drv, p2_sel, ck_run;
  logic [7:0] wdata, p0_lat, p2_lat, p2_adr, alt;
  // design outputs
  logic [7:0] rdata, p0, p2, alt_o;
  logic       osc, cpu, per, wdg, idl, pdn, wake, ale, crd, p0_oe_n, ckout;
  // bookkeeping
  int         bad_count, compares, k, g;
  logic       brk;
  logic [7:0] a, b, r;
  psm_mode_t  m;

  psm_ctrl #(.PORT_W(8)) i_psm_ctrl (
    .CLK_I(clk), .RST_I(rst), .INSTR_DONE_I(done), .POWER_CONTROL_REGISTER_WR_I(wr),
    .POWER_CONTROL_REGISTER_WDATA_I(wdata), .POWER_CONTROL_REGISTER_RDATA_O(rdata), .PERMIT_N_I(permit_n),
    .IRQ_PENDING_I(irq), .EXT_CODE_I(ext), .ALE_RUN_I(1'b1),
    .CODE_RD_RUN_I(1'b1), .P0_LATCH_I(p0_lat), .P2_LATCH_I(p2_lat),
    .P2_ADDR_I(p2_adr), .P0_DRIVE_RUN_I(p0_drv), .P2_ADDR_SEL_I(p2_sel),
    .ALT_OUT_I(alt), .CLOCK_OUTPUT_PIN_EN_I(1'b1), .CLOCK_OUTPUT_PIN_RUN_I(ck_run),
    .OSC_RUN_O(osc), .CPU_CLK_EN_O(cpu), .PERIPH_CLK_EN_O(per),
    .WDOG_CLK_EN_O(wdg), .IDLE_O(idl), .PDOWN_O(pdn), .WAKE_IRQ_O(wake),
    .ALE_O(ale), .CODE_RD_O(crd), .P0_O(p0), .P0_OE_N_O(p0_oe_n),
    .P2_O(p2), .ALT_O(alt_o), .CLOCK_OUTPUT_PIN_O(ckout)
  );

  // free running clock
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  // expected {osc,cpu,periph,wdog,idle,pdown,ale,code_rd} for a mode
  function automatic logic [7:0] exp_st(input psm_mode_t md);
    case (md)
      PSM_IDLE: exp_st = 8'hAB;
      PSM_PD:   exp_st = 8'h04;
      default:  exp_st = 8'hF3;
    endcase
  endfunction : exp_st

  // compare two bytes, four-state exact
  task automatic chk(input logic [7:0] got, input logic [7:0] exp,
                     input string what);
    compares++;
    if (got !== exp) begin
      bad_count++;
      $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : chk

  // mode outputs sampled mid-cycle, after the edge has settled
  task automatic st(input psm_mode_t md);
    @(negedge clk);
    chk({osc, cpu, per, wdg, idl, pdn, ale, crd}, exp_st(md), "mode");
  endtask : st

  // one completed instruction, optionally writing the register
  task automatic ins(input logic w, input logic [7:0] d);
    @(posedge clk);
    done  <= 1'b1;
    wr    <= w;
    wdata <= d;
  endtask : ins

  // cycles with no instruction completing
  task automatic quiet(input int n);
    repeat (n) begin
      @(posedge clk);
      done <= 1'b0;
      wr   <= 1'b0;
    end
  endtask : quiet

  // reset held two machine cycles, as the idle exit allows
  task automatic do_reset;
    @(posedge clk);
    rst <= 1'b1;
    irq <= 1'b0;
    repeat (PSM_IDLE_RST_CLKS) @(posedge clk);
    rst <= 1'b0;
    st(PSM_RUN);
    chk(rdata, PSM_POWER_CONTROL_REGISTER_RST, "reset read");
  endtask : do_reset

  // port pins while a mode holds
  task automatic pins(input psm_mode_t md);
    chk({7'h00, p0_oe_n}, {7'h00, ext}, "p0 float");
    if (!ext) chk(p0, p0_lat, "p0 data");
    chk(p2, (ext && md == PSM_IDLE) ? p2_adr : p2_lat, "p2");
  endtask : pins

  // verdict, reached from the main sequence or the watchdog
  task automatic complete_run;
    $display("compares %0d mismatches %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : complete_run

  // hang guard, well beyond the longest expected run
  initial begin
    repeat (8000) @(posedge clk);
    bad_count++;
    $display("[FAIL] %0t watchdog expired", $time);
    complete_run();
  end

  // main sequence: eight kinds of entry attempt, four rounds each
  initial begin
    {rst, done, wr, permit_n, irq, ext, p0_drv, p2_sel, ck_run} = 9'h100;
    {wdata, p0_lat, p2_lat, p2_adr, alt} = 40'h00_0000_0000;
    void'($urandom(90723));
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    st(PSM_RUN);
    chk(rdata, PSM_POWER_CONTROL_REGISTER_RST, "first read");
    for (int i = 0; i < 32; i++) begin
      k   = i % 8;
      g   = 0;
      brk = 1'b0;
      m   = PSM_RUN;
      r   = 8'($urandom) & 8'h8C;
      // fresh pin data; permit released only for the blocked kind
      @(posedge clk);
      {p0_lat, p2_lat, p2_adr, alt} <= 32'($urandom);
      {ext, p0_drv, p2_sel, ck_run} <= 4'($urandom);
      permit_n <= (k == 6);
      case (k)
        0: begin a = 8'h01; b = 8'h20; m = PSM_IDLE; end
        1: begin a = 8'h01; b = 8'h20; m = PSM_IDLE; g = 2; end
        2: begin a = 8'h02; b = 8'h40; m = PSM_PD; end
        3: begin a = 8'h21; b = 8'h20; end
        4: begin a = 8'h42; b = 8'h40; end
        5: begin a = 8'h01; b = 8'h20; brk = 1'b1; end
        6: begin a = 8'h02; b = 8'h40; end
        default: begin a = 8'h03; b = 8'h60; m = PSM_PD; end
      endcase
      // arm write, optional intruder or gap, then start write
      ins(1'b1, a | r);
      if (brk) ins(1'b0, 8'h20);
      if (g > 0) quiet(g);
      ins(1'b1, b | r);
      quiet(1);
      st(m);
      chk(rdata, r, "read back");
      if (m == PSM_IDLE) begin
        pins(m);
        chk(alt_o, alt, "alt live");
        chk({7'h00, ckout}, {7'h00, ck_run}, "clock out live");
        if (k == 0) begin
          @(posedge clk);
          irq <= 1'b1;
          st(PSM_IDLE);
          chk({7'h00, wake}, 8'h01, "wake");
          @(posedge clk);
          irq <= 1'b0;
          st(PSM_RUN);
        end else begin
          do_reset();
        end
      end else if (m == PSM_PD) begin
        pins(m);
        // pins move and an interrupt arrives; nothing may change
        @(posedge clk);
        alt <= ~alt;
        irq <= 1'b1;
        st(PSM_PD);
        chk(alt_o, ~alt, "alt frozen");
        chk({7'h00, ckout}, 8'h00, "clock out low");
        do_reset();
      end
      $display("test %0d kind %0d done", i, k);
    end
    complete_run();
  end
endmodule : psm_ctrl_tb
